// File: asr_defs.svh
// Timing constants and pin widths for the asynchronous RAM host controller
// Assumes a 20 MHz system clock and a fast-grade memory by default
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

`define ASR_CLK_PERIOD_NS 50
`define ASR_ADDR_W 13
`define ASR_DATA_W 8
`define ASR_WORDS 8192
// Fast grade figures
`define ASR_CYCLE_NS_FAST 55
`define ASR_DATA_SETUP_NS_FAST 20
// Slow grade figures
`define ASR_CYCLE_NS_SLOW 70
`define ASR_DATA_SETUP_NS_SLOW 30
// Read data hold after address change
`define ASR_HOLD_NS 10
// Least times round up to whole cycles
`define ASR_CYC_UP(ns) (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)

`endif

// File: asr_pkg.sv
// Types shared by the asynchronous RAM host controller
// Assumes asr_defs.svh is on the include path
`include "asr_defs.svh"

package asr_pkg;

	// Pin bundle driven toward the memory
	typedef struct packed {
		logic [`ASR_ADDR_W-1:0] word_select_lines;
		logic select_low_active_n;
		logic select_high_active;
		logic write_strobe_n;
		logic output_gate_n;
	} asr_pins_type;

	// User request
	typedef struct packed {
		logic write;
		logic [`ASR_ADDR_W-1:0] addr;
		logic [`ASR_DATA_W-1:0] wdata;
	} asr_req_type;

	typedef enum logic [5:0] {
		ASR_IDLE = 6'h01,
		ASR_RSET = 6'h02,
		ASR_RACC = 6'h04,
		ASR_WSET = 6'h08,
		ASR_WPUL = 6'h10,
		ASR_WEND = 6'h20
	} asr_state_type;

endpackage

// File: asr_wait_timer.sv
// Cycle counter used to stretch the read access and write pulse phases of an access
// Assumes one clock; load and count in the same domain
`timescale 1ns/1ns

module asr_wait_timer import asr_pkg::*; #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	// Status
	output logic done
);

	logic [WIDTH-1:0] cnt_reg;

	if (WIDTH < 2) begin : g_bad_width
		$error("asr_wait_timer: WIDTH too small");
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else if (load) begin
			cnt_reg <= count;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			done <= 1'b0;
		end else begin
			done <= !load && (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end

endmodule

// File: asr_host.sv
// Host controller for an 8K x 8 asynchronous static RAM
// Assumes data_lines_in comes straight from the pins and is not synchronous to clk
`timescale 1ns/1ns

module asr_host import asr_pkg::*; #(
	parameter bit SLOW_GRADE = 1'b0,
	parameter int ADDR_W = `ASR_ADDR_W,
	parameter int DATA_W = `ASR_DATA_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// User request
	input wire logic req_valid,
	input wire asr_req_type req,
	output logic req_ready,
	// User answer
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	// Memory control pins
	output asr_pins_type pins,
	// Memory data lines
	input wire logic [DATA_W-1:0] data_lines_in,
	output logic [DATA_W-1:0] data_lines_out,
	output logic data_lines_oe
);

	localparam int CYCLE_NS = SLOW_GRADE ? `ASR_CYCLE_NS_SLOW : `ASR_CYCLE_NS_FAST;
	localparam int SETUP_NS = SLOW_GRADE ? `ASR_DATA_SETUP_NS_SLOW : `ASR_DATA_SETUP_NS_FAST;
	localparam int ACC_CYC = `ASR_CYC_UP(CYCLE_NS);
	localparam int SETUP_CYC = `ASR_CYC_UP(SETUP_NS);
	localparam int PULSE_CYC = (ACC_CYC > SETUP_CYC) ? ACC_CYC : SETUP_CYC;
	localparam int TW = 4;

	if (ADDR_W != `ASR_ADDR_W || DATA_W != `ASR_DATA_W) begin : g_bad_width
		$error("asr_host: bus widths must match the memory");
	end
	if (ACC_CYC + 2 >= (1 << TW) || PULSE_CYC >= (1 << TW)) begin : g_bad_timer
		$error("asr_host: timer too narrow");
	end

	// ----------------------------------------
	// Pin input synchroniser
	// ----------------------------------------
	logic [DATA_W-1:0] din_meta_reg;
	logic [DATA_W-1:0] din_sync_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			din_meta_reg <= '0;
			din_sync_reg <= '0;
		end else begin
			din_meta_reg <= data_lines_in;
			din_sync_reg <= din_meta_reg;
		end
	end

	// ----------------------------------------
	// Phase timer
	// ----------------------------------------
	logic tmr_load;
	logic [TW-1:0] tmr_count;
	logic tmr_done;

	asr_wait_timer #(.WIDTH(TW)) u_timer (
		.clk(clk),
		.nrst(nrst),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	asr_state_type state_reg;
	asr_state_type state_next;

	function automatic logic [TW-1:0] cyc(input int n);
		return TW'(n);
	endfunction

	always_comb begin
		state_next = state_reg;
		tmr_load = 1'b0;
		tmr_count = '0;
		case (state_reg)
			ASR_IDLE: begin
				if (req_valid) begin
					// Address settles one cycle before selects go active
					state_next = req.write ? ASR_WSET : ASR_RSET;
				end
			end
			ASR_RSET: begin
				state_next = ASR_RACC;
				// Selects held past access time plus two sync stages
				tmr_load = 1'b1;
				tmr_count = cyc(ACC_CYC + 2);
			end
			ASR_RACC: begin
				if (tmr_done) state_next = ASR_IDLE;
			end
			ASR_WSET: begin
				state_next = ASR_WPUL;
				// Pulse covers select, address and data lead times
				tmr_load = 1'b1;
				tmr_count = cyc(PULSE_CYC);
			end
			ASR_WPUL: begin
				if (tmr_done) state_next = ASR_WEND;
			end
			ASR_WEND: begin
				state_next = ASR_IDLE;
			end
			default: begin
				state_next = ASR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ASR_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Request latch and handshake
	// ----------------------------------------
	logic [ADDR_W-1:0] addr_reg;
	logic [DATA_W-1:0] wdata_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_reg <= '0;
			wdata_reg <= '0;
		end else if (state_reg == ASR_IDLE && req_valid) begin
			// One byte per access over 13 address bits
			addr_reg <= req.addr;
			wdata_reg <= req.wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (state_next == ASR_IDLE) && !(state_reg == ASR_IDLE && req_valid);
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pins.word_select_lines <= '0;
			pins.select_low_active_n <= 1'b1;
			pins.select_high_active <= 1'b0;
			pins.write_strobe_n <= 1'b1;
			pins.output_gate_n <= 1'b1;
		end else begin
			// Address stays put from setup through the end of the access
			pins.word_select_lines <= (state_reg == ASR_IDLE && req_valid) ? req.addr : addr_reg;
			// Both selects together or neither; idle leaves the memory in standby
			pins.select_low_active_n <= !(state_next == ASR_RACC || state_next == ASR_WPUL);
			pins.select_high_active <= (state_next == ASR_RACC || state_next == ASR_WPUL);
			// Strobe falls with the selects and rises with them, ending the write
			pins.write_strobe_n <= !(state_next == ASR_WPUL);
			// Gate low only for reads; high through writes
			pins.output_gate_n <= !(state_next == ASR_RACC);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_lines_out <= '0;
			data_lines_oe <= 1'b0;
		end else begin
			// Data driven before the strobe and held one cycle past its rise
			data_lines_out <= (state_reg == ASR_IDLE && req_valid) ? req.wdata : wdata_reg;
			// Never driven while the gate may be low
			data_lines_oe <= (state_next == ASR_WSET || state_next == ASR_WPUL || state_next == ASR_WEND)
				&& state_next != ASR_RACC;
		end
	end

	// ----------------------------------------
	// Read capture
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else begin
			// Sampled at the last selected cycle, address unchanged so data holds
			rd_valid <= (state_reg == ASR_RACC) && tmr_done;
			if (state_reg == ASR_RACC && tmr_done) rd_data <= din_sync_reg;
		end
	end

endmodule

// File: asr_host_monitor.sv
// Pin checker for the RAM host controller
// Assumes it is bound onto asr_host
`timescale 1ns/1ns
`include "asr_defs.svh"

module asr_host_monitor import asr_pkg::*; #(
	parameter bit SLOW_GRADE = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// User side
	input wire logic req_valid,
	input wire asr_req_type req,
	input wire logic req_ready,
	input wire logic rd_valid,
	input wire logic [`ASR_DATA_W-1:0] rd_data,
	// Memory side
	input wire asr_pins_type pins,
	input wire logic [`ASR_DATA_W-1:0] data_lines_in,
	input wire logic [`ASR_DATA_W-1:0] data_lines_out,
	input wire logic data_lines_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire sel = !pins.select_low_active_n && pins.select_high_active;

	// ----------------
	// Properties
	// ----------------
	a_select_pair: assert property (pins.select_low_active_n == !pins.select_high_active)
		else $error("selects not paired");
	a_strobe_selected: assert property (!pins.write_strobe_n |-> sel)
		else $error("strobe outside select");
	a_gate_in_write: assert property (!pins.write_strobe_n |-> pins.output_gate_n)
		else $error("gate low in write");
	a_no_contention: assert property (sel && !pins.output_gate_n |-> !data_lines_oe)
		else $error("host drives during read");
	a_select_width: assert property ($fell(pins.select_low_active_n) |-> sel [*2])
		else $error("select too short");
	a_addr_stable: assert property (sel |-> $stable(pins.word_select_lines))
		else $error("address moved while selected");
	a_data_setup: assert property (!pins.write_strobe_n |-> data_lines_oe && $stable(data_lines_out))
		else $error("write data not steady");
	a_data_hold: assert property ($rose(pins.write_strobe_n) |-> data_lines_oe && $stable(data_lines_out))
		else $error("write data not held");
	a_read_answer: assert property ($fell(pins.select_low_active_n) && pins.write_strobe_n |-> ##[5:7] rd_valid)
		else $error("read answer late");
endmodule

bind asr_host asr_host_monitor #(.SLOW_GRADE(SLOW_GRADE)) i_mon (.clk(clk), .nrst(nrst), .req_valid(req_valid),
	.req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins),
	.data_lines_in(data_lines_in), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));

// File: asr_sram_model.sv
// Behavioural model of the 8K x 8 asynchronous RAM
// Assumes the bench resolves the shared data lines
`timescale 1ns/1ns
`include "asr_defs.svh"

module asr_sram_model import asr_pkg::*; #(
	parameter int ACC_NS = 55
) (
	// Control pins
	input wire asr_pins_type pins,
	// Data lines
	input wire logic [7:0] dq,
	output logic [7:0] mem_q,
	output logic mem_oe
);
	// ----------------
	// Array and modes
	// ----------------
	logic [7:0] arr [0:`ASR_WORDS-1];
	wire sel = !pins.select_low_active_n && pins.select_high_active;
	assign mem_oe = sel && pins.write_strobe_n && !pins.output_gate_n;
	assign #(ACC_NS) mem_q = arr[pins.word_select_lines];
	always @(pins or dq) begin
		if (!pins.select_low_active_n && pins.select_high_active && !pins.write_strobe_n)
			arr[pins.word_select_lines] = dq;
	end
endmodule

// File: tb_top.sv
// Bench for the RAM host controller
// Assumes the RAM model and bound checker
`timescale 1ns/1ns

module tb_top import asr_pkg::*;;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic req_valid = 1'b0;
	asr_req_type req = '0;
	logic req_ready, rd_valid, data_lines_oe, mem_oe;
	logic [7:0] rd_data, host_q, mem_q, dq;
	logic [7:0] float_pat = 8'h5A;
	asr_pins_type pins;
	logic [7:0] shadow [logic [12:0]];
	logic [7:0] expq [$];
	int miscompares = 0;
	int n_tests = 0;

	// ----------------
	// Wiring
	// ----------------
	assign dq = data_lines_oe ? host_q : (mem_oe ? mem_q : float_pat);
	asr_host i_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .data_lines_in(dq), .data_lines_out(host_q),
		.data_lines_oe(data_lines_oe));
	asr_sram_model i_mem (.pins(pins), .dq(dq), .mem_q(mem_q), .mem_oe(mem_oe));
	initial forever #25 clk = ~clk;
	always @(posedge clk) float_pat <= float_pat + 8'h3B;

	task automatic fail(input string m);
		miscompares++;
		$display("unexpected at %0t: %s", $time, m);
	endtask

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic do_req(input logic w, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk);
		while (req_ready !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk);
		end
		if (n == 50) fail("controller never ready");
		req_valid = 1'b1;
		req = '{w, a, d};
		@(negedge clk);
		n_tests++;
		if (req_ready !== 1'b0) fail("request not taken");
		req_valid = 1'b0;
		if (w) shadow[a] = d;
		else expq.push_back(shadow[a]);
	endtask

	always @(negedge clk) begin
		if (rd_valid === 1'b1) begin
			n_tests++;
			if (expq.size() == 0) fail("read answer without request");
			else if (rd_data !== expq.pop_front()) fail("read data differs");
		end
		if (data_lines_oe === 1'b1 && mem_oe === 1'b1) fail("data line contention");
	end

	initial begin
		logic [12:0] a;
		logic w;
		void'($urandom(98129));
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		n_tests++;
		if (pins.select_low_active_n !== 1'b1 || pins.select_high_active !== 1'b0) fail("not idle");
		do_req(1'b1, 13'h0000, 8'hC3);
		do_req(1'b1, 13'h1FFF, 8'h3C);
		do_req(1'b1, 13'h1FFF, 8'h96);
		do_req(1'b0, 13'h0000, 8'h00);
		do_req(1'b0, 13'h1FFF, 8'h00);
		for (int i = 0; i < 300; i++) begin
			a = 13'($urandom % 16) | ((i % 2) ? 13'h1FF0 : 13'h0000);
			w = 1'($urandom % 2);
			if (!shadow.exists(a)) w = 1'b1;
			do_req(w, a, 8'($urandom));
		end
		repeat (20) @(negedge clk);
		n_tests++;
		if (expq.size() != 0) fail("read answers missing");
		stop_test();
	end

	initial begin
		#1000000;
		fail("watchdog expired");
		stop_test();
	end
endmodule
